// File: design/tccp_timer.sv
// Four-channel capture/compare timer with pulse count and port pins
//
// The implementer's own choices: the placing of the registers and the APB slave port.
`default_nettype none
module tccp_timer
  import tccp_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] pin_in,
  output logic [3:0] pin_out,
  output logic [3:0] pin_oe,
  output logic [3:0] irq
);
  tccp_state_t q;
  tccp_state_t next_q;
  logic tick;
  logic access;
  logic wr;
  logic ch3_hit;
  logic [3:0] oc_active;
  logic [3:0] match;
  logic [3:0] cmp;
  logic [3:0] rise;
  logic [3:0] fall;
  logic [3:0] cap;
  logic [3:0] force_vec;
  logic [3:0] flag_clr;

  // Low bits that must all be one for a tick
  function automatic logic [6:0] presc_mask(input logic [2:0] sel);
    presc_mask = PRESC_FULL >> (PRESC_MAX_SEL - sel);
  endfunction

  function automatic logic oc_action(input logic om, input logic ol, input logic cur);
    unique case ({om, ol})
      ACT_NONE: oc_action = cur;
      ACT_TOGGLE: oc_action = ~cur;
      ACT_CLEAR: oc_action = 1'b0;
      ACT_SET: oc_action = 1'b1;
    endcase
  endfunction

  // Read mux: {error, data}
  function automatic logic [32:0] read_reg(input tccp_state_t s, input logic [11:0] a);
    logic [31:0] d;
    logic err;
    d = DATA_ZERO;
    err = 1'b0;
    unique case (a)
      OFF_CTRL: begin
        d[CTRL_PRESC_LSB +: 3] = s.presc_sel;
        d[CTRL_CRE_BIT] = s.cnt_rst_en;
      end
      OFF_IOSEL: d[3:0] = s.io_sel;
      OFF_OUTACT: d[7:0] = {s.out_mode, s.out_level};
      OFF_EDGE: d[7:0] = {s.edge_fall, s.edge_rise};
      OFF_FORCE: d = DATA_ZERO;
      OFF_CH3: begin
        d[3:0] = s.ch3_mask;
        d[CH3_DATA_LSB +: 4] = s.ch3_data;
      end
      OFF_IRQEN: d[3:0] = s.irq_en;
      OFF_FLAGS: d[3:0] = s.flags;
      OFF_COUNT: d[15:0] = s.count;
      OFF_VALUE0: d[15:0] = s.value[0];
      OFF_VALUE1: d[15:0] = s.value[1];
      OFF_VALUE2: d[15:0] = s.value[2];
      OFF_VALUE3: d[15:0] = s.value[3];
      OFF_PCOUNT: d[15:0] = s.pulse_count;
      OFF_PORT: d[3:0] = (s.port_dir & s.port_data) | (~s.port_dir & s.sync2);
      OFF_DIR: d[3:0] = s.port_dir;
      default: err = 1'b1;
    endcase
    read_reg = {err, d};
  endfunction

  assign tick = (q.presc & presc_mask(q.presc_sel)) == presc_mask(q.presc_sel);
  assign oc_active = q.io_sel & (q.out_mode | q.out_level);
  assign rise = q.sync2 & ~q.prev;
  assign fall = ~q.sync2 & q.prev;
  assign cap = ~q.io_sel & ~q.port_dir & ((rise & q.edge_rise) | (fall & q.edge_fall));
  assign cmp = match & q.io_sel & {TCCP_CH{tick}};
  assign ch3_hit = cmp[CH3];
  assign access = psel & penable;
  assign wr = access & q.pready & pwrite;
  assign force_vec = (wr && paddr == OFF_FORCE) ? (pwdata[3:0] & q.io_sel) : NIB_ZERO;
  assign flag_clr = (wr && paddr == OFF_FLAGS) ? pwdata[3:0] : NIB_ZERO;

  genvar g;
  generate
    for (g = 0; g < TCCP_CH; g++) begin : g_match
      assign match[g] = q.count == q.value[g];
    end
  endgenerate

  always_comb begin
    next_q = q;
    // Two-stage synchroniser, then edge history
    next_q.sync1 = pin_in;
    next_q.sync2 = q.sync1;
    next_q.prev = q.sync2;
    next_q.presc = q.presc + PRESC_STEP;
    if (tick) begin
      if (ch3_hit && q.cnt_rst_en) begin
        next_q.count = COUNT_ZERO;
      end else begin
        next_q.count = q.count + COUNT_STEP;
      end
    end
    if (rise[PULSE_CH]) begin
      next_q.pulse_count = q.pulse_count + COUNT_STEP;
    end
    for (int i = 0; i < TCCP_CH; i++) begin
      if (cap[i]) begin
        next_q.value[i] = q.count;
      end
      if (cmp[i] || force_vec[i]) begin
        next_q.oc_level[i] = oc_action(q.out_mode[i], q.out_level[i], q.oc_level[i]);
      end
      // Channel 3 wins over the channel's own action
      if (ch3_hit && q.ch3_mask[i]) begin
        next_q.oc_level[i] = q.ch3_data[i];
        next_q.port_data[i] = q.ch3_data[i];
      end
    end
    // Hardware set wins over software clear
    next_q.flags = (q.flags & ~flag_clr) | cap | cmp;
    if (access && !q.pready) begin
      next_q.pready = 1'b1;
      {next_q.pslverr, next_q.prdata} = read_reg(q, paddr);
    end else begin
      next_q.pready = 1'b0;
      next_q.pslverr = 1'b0;
      next_q.prdata = DATA_ZERO;
    end
    if (wr) begin
      unique case (paddr)
        OFF_CTRL: begin
          next_q.presc_sel = pwdata[CTRL_PRESC_LSB +: 3];
          next_q.cnt_rst_en = pwdata[CTRL_CRE_BIT];
        end
        OFF_IOSEL: next_q.io_sel = pwdata[3:0];
        OFF_OUTACT: begin
          next_q.out_level = pwdata[3:0];
          next_q.out_mode = pwdata[HI_NIB_LSB +: 4];
        end
        OFF_EDGE: begin
          next_q.edge_rise = pwdata[3:0];
          next_q.edge_fall = pwdata[HI_NIB_LSB +: 4];
        end
        OFF_CH3: begin
          next_q.ch3_mask = pwdata[3:0];
          next_q.ch3_data = pwdata[CH3_DATA_LSB +: 4];
        end
        OFF_IRQEN: next_q.irq_en = pwdata[3:0];
        OFF_COUNT: next_q.count = pwdata[15:0];
        OFF_VALUE0: next_q.value[0] = pwdata[15:0];
        OFF_VALUE1: next_q.value[1] = pwdata[15:0];
        OFF_VALUE2: next_q.value[2] = pwdata[15:0];
        OFF_VALUE3: next_q.value[3] = pwdata[15:0];
        OFF_PCOUNT: next_q.pulse_count = pwdata[15:0];
        OFF_PORT: next_q.port_data = pwdata[3:0];
        OFF_DIR: next_q.port_dir = pwdata[3:0];
        default: next_q.port_dir = q.port_dir;
      endcase
    end
    // Compare overrides direction, port latch drives released pins
    next_q.pin_oe = oc_active | q.port_dir;
    next_q.pin_out = (oc_active & q.oc_level) | (~oc_active & q.port_data);
    next_q.irq = q.flags & q.irq_en;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else if (ce) begin
      q <= next_q;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign pin_out = q.pin_out;
  assign pin_oe = q.pin_oe;
  assign irq = q.irq;

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  count_step_a: assert property (
    ce && tick && !ch3_hit && !(wr && paddr == OFF_COUNT)
    |=> q.count == $past(q.count) + COUNT_STEP)
    else $error("counter did not advance");

  count_reset_a: assert property (
    ce && ch3_hit && q.cnt_rst_en && !(wr && paddr == OFF_COUNT)
    |=> q.count == COUNT_ZERO)
    else $error("channel 3 did not clear counter");

  pulse_inc_a: assert property (
    ce && rise[PULSE_CH] && !(wr && paddr == OFF_PCOUNT)
    |=> q.pulse_count == $past(q.pulse_count) + COUNT_STEP)
    else $error("pulse edge lost");

  pulse_sync_a: assert property (
    ce ##1 ce ##1 ce && $rose(q.sync2[PULSE_CH])
    |-> $past(pin_in[PULSE_CH], 2))
    else $error("pulse input not synchronised");

  capture_val_a: assert property (
    ce && cap[0] && !(wr && paddr == OFF_VALUE0)
    |=> q.value[0] == $past(q.count))
    else $error("capture missed counter");

  capture_dir_a: assert property (
    q.port_dir[1]
    |-> !cap[1])
    else $error("capture on output pin");

  flag_set_a: assert property (
    ce && (cap[2] || cmp[2])
    |=> q.flags[2] ##1 (!ce || irq[2] == q.irq_en[2]))
    else $error("flag or request wrong");

  force_flag_a: assert property (
    ce && force_vec[1] && !cmp[1] && !q.flags[1]
    |=> !q.flags[1])
    else $error("force set flag");

  ch3_copy_a: assert property (
    ce && ch3_hit && q.ch3_mask[0] && !(wr && paddr == OFF_PORT)
    |=> q.port_data[0] == $past(q.ch3_data[0]))
    else $error("channel 3 data not copied");

  pin_drive_a: assert property (
    ce && oc_active[2]
    |=> pin_oe[2] && pin_out[2] == $past(q.oc_level[2]))
    else $error("compare pin not driven");

  gp_out_a: assert property (
    ce && !oc_active[3] && q.port_dir[3]
    |=> pin_oe[3] && pin_out[3] == $past(q.port_data[3]))
    else $error("port latch not on pin");

  apb_wait_a: assert property (
    ce && access && !pready
    |=> pready ##1 (!ce || !pready))
    else $error("bus answer timing wrong");

  ready_pulse_a: assert property (
    ce && pready
    |=> !pready)
    else $error("ready held too long");

  bad_addr_a: assert property (
    ce && access && !pready && paddr > OFF_DIR
    |=> pslverr)
    else $error("unmapped address not refused");

  good_addr_a: assert property (
    ce && access && !pready && paddr == OFF_DIR
    |=> !pslverr)
    else $error("mapped address refused");

  idle_data_a: assert property (
    ce && !(access && !pready)
    |=> prdata == DATA_ZERO)
    else $error("read data outside answer");

  dir_write_a: assert property (
    ce && wr && paddr == OFF_DIR
    |=> q.port_dir == $past(pwdata[3:0]))
    else $error("direction write lost");

  dir_hold_a: assert property (
    ce && !(wr && paddr == OFF_DIR)
    |=> q.port_dir == $past(q.port_dir))
    else $error("direction changed by hardware");

  port_write_a: assert property (
    ce && wr && paddr == OFF_PORT
    |=> q.port_data == $past(pwdata[3:0]))
    else $error("port latch write lost");

  port_latch_rd_a: assert property (
    ce && access && !pready && paddr == OFF_PORT && q.port_dir[0]
    |=> prdata[0] == $past(q.port_data[0]))
    else $error("output bit read not latch");

  port_pin_rd_a: assert property (
    ce && access && !pready && paddr == OFF_PORT && !q.port_dir[1]
    |=> prdata[1] == $past(q.sync2[1]))
    else $error("input bit read not pin");

  presc_div1_a: assert property (
    q.presc_sel == '0
    |-> tick)
    else $error("divide by one missed tick");

  presc_div128_a: assert property (
    tick && q.presc_sel == PRESC_MAX_SEL
    |-> q.presc == PRESC_FULL)
    else $error("divide by 128 ticked early");

  count_hold_a: assert property (
    ce && !tick && !(wr && paddr == OFF_COUNT)
    |=> q.count == $past(q.count))
    else $error("counter moved without tick");

  count_load_a: assert property (
    ce && wr && paddr == OFF_COUNT
    |=> q.count == $past(pwdata[15:0]))
    else $error("counter write lost");

  pulse_hold_a: assert property (
    ce && !rise[PULSE_CH] && !(wr && paddr == OFF_PCOUNT)
    |=> q.pulse_count == $past(q.pulse_count))
    else $error("pulse count moved without edge");

  pulse_write_a: assert property (
    ce && wr && paddr == OFF_PCOUNT
    |=> q.pulse_count == $past(pwdata[15:0]))
    else $error("pulse count write lost");

  capture_val1_a: assert property (
    ce && cap[1] && !(wr && paddr == OFF_VALUE1)
    |=> q.value[1] == $past(q.count))
    else $error("capture one missed counter");

  capture_sel_a: assert property (
    q.io_sel[0]
    |-> !cap[0])
    else $error("capture on compare channel");

  cmp_flag_a: assert property (
    ce && cmp[1]
    |=> q.flags[1])
    else $error("compare flag not set");

  cmp_set_a: assert property (
    ce && cmp[1] && q.out_mode[1] && q.out_level[1] && !(ch3_hit && q.ch3_mask[1])
    |=> q.oc_level[1])
    else $error("compare did not set level");

  cmp_clear_a: assert property (
    ce && cmp[1] && q.out_mode[1] && !q.out_level[1] && !(ch3_hit && q.ch3_mask[1])
    |=> !q.oc_level[1])
    else $error("compare did not clear level");

  pin_release_a: assert property (
    ce && !oc_active[1] && !q.port_dir[1]
    |=> !pin_oe[1])
    else $error("disconnected pin still driven");

  ch3_prio_a: assert property (
    ce && ch3_hit && q.ch3_mask[1]
    |=> q.oc_level[1] == $past(q.ch3_data[1]))
    else $error("channel 3 did not override");

  irq_mask_a: assert property (
    ce && !q.irq_en[0]
    |=> !irq[0])
    else $error("request without enable");

  flag_clear_a: assert property (
    ce && flag_clr[3] && !cap[3] && !cmp[3]
    |=> !q.flags[3])
    else $error("flag clear lost");

  ce_freeze_a: assert property (
    !ce
    |=> q.count == $past(q.count) && pready == $past(pready))
    else $error("state moved with enable low");
endmodule
`default_nettype wire

// File: design/tccp_pkg.sv
// Constants and state type of the timer capture/compare port block
// What this block does
// - Keep a 16-bit pulse count of rising edges on pin 3, readable and writable anytime.
// - Synchronise the pulse input to the clock before counting it.
// - Port data writes are buffered; they drive only general-purpose output pins.
// - Port data read returns pin level when direction is 0, latch when 1.
// - Direction bit 1 means output, 0 input; reset clears all of them.
// - One 16-bit free-running counter shared by four channels plus pulse count.
// - Prescaler divides the clock by 1 to 128 under a 3-bit select.
// - I/O select 0 makes a capture channel; active edge copies the counter.
// - Capture never changes direction; only input-configured pins can capture.
// - Each capture sets the channel flag; flag requests interrupt when enabled.
// - I/O select 1 makes compare; match sets, clears or toggles pin, sets flag.
// - Mode and level bits choose the action; both zero disconnects the pin.
// - Writing 1 to force compare acts at once without setting the flag.
// - A channel 3 compare overrides simultaneous compares on the channels selected by its mask.
// - Channel 3 compare copies its data bits into port data under the mask.
// - With counter reset enabled a channel 3 compare clears the counter.
// - An active compare drives its pin whatever the direction bit holds.
// - Port writes on a compare pin are latched and appear when released.
`default_nettype none
package tccp_pkg;
  localparam int TCCP_CH = 4;
  localparam int TCCP_AW = 12;
  localparam int PULSE_CH = 3;
  localparam int CH3 = 3;
  // Register byte offsets
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_IOSEL = 12'h004;
  localparam logic [11:0] OFF_OUTACT = 12'h008;
  localparam logic [11:0] OFF_EDGE = 12'h00C;
  localparam logic [11:0] OFF_FORCE = 12'h010;
  localparam logic [11:0] OFF_CH3 = 12'h014;
  localparam logic [11:0] OFF_IRQEN = 12'h018;
  localparam logic [11:0] OFF_FLAGS = 12'h01C;
  localparam logic [11:0] OFF_COUNT = 12'h020;
  localparam logic [11:0] OFF_VALUE0 = 12'h024;
  localparam logic [11:0] OFF_VALUE1 = 12'h028;
  localparam logic [11:0] OFF_VALUE2 = 12'h02C;
  localparam logic [11:0] OFF_VALUE3 = 12'h030;
  localparam logic [11:0] OFF_PCOUNT = 12'h034;
  localparam logic [11:0] OFF_PORT = 12'h038;
  localparam logic [11:0] OFF_DIR = 12'h03C;
  // Field positions
  localparam int CTRL_PRESC_LSB = 0;
  localparam int CTRL_CRE_BIT = 3;
  localparam int HI_NIB_LSB = 4;
  localparam int CH3_DATA_LSB = 8;
  // Compare action codes {mode, level}
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;
  localparam logic [6:0] PRESC_FULL = 7'h7F;
  localparam logic [2:0] PRESC_MAX_SEL = 3'h7;
  localparam logic [6:0] PRESC_STEP = 7'h01;
  localparam logic [15:0] COUNT_STEP = 16'h0001;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
  localparam logic [3:0] NIB_ZERO = 4'h0;

  typedef struct packed {
    logic [2:0] presc_sel;
    logic cnt_rst_en;
    logic [3:0] io_sel;
    logic [3:0] out_mode;
    logic [3:0] out_level;
    logic [3:0] edge_rise;
    logic [3:0] edge_fall;
    logic [3:0] ch3_mask;
    logic [3:0] ch3_data;
    logic [3:0] irq_en;
    logic [3:0] flags;
    logic [3:0] port_data;
    logic [3:0] port_dir;
    logic [3:0] oc_level;
    logic [6:0] presc;
    logic [15:0] count;
    logic [3:0][15:0] value;
    logic [15:0] pulse_count;
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] prev;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [3:0] pin_out;
    logic [3:0] pin_oe;
    logic [3:0] irq;
  } tccp_state_t;
endpackage
`default_nettype wire

// File: verification/tccp_pins.sv
// Model of the external pins around the timer
`default_nettype none
module tccp_pins (
  input wire logic [3:0] pin_out,
  input wire logic [3:0] pin_oe,
  input wire logic [3:0] ext_lvl,
  output logic [3:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // Device drive wins where enabled
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : ext_lvl[i];
    end
  end
endmodule
`default_nettype wire

// File: verification/tccp_timer_tb.sv
// Self-checking bench for the timer capture/compare block
`default_nettype none
module tccp_timer_tb import tccp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rstn, ce, psel, penable, pwrite, pready, pslverr, ev;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [3:0] pin_in, pin_out, pin_oe, irq, ext_lvl;
  int error_cnt = 0;
  int n_checks = 0;
  tccp_timer tccp_timer_i (.clk(clk), .rstn(rstn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq));
  tccp_pins tccp_pins_i (.pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext_lvl), .pin_in(pin_in));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(negedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      chk("apb wait", 32'h0000_0001, 32'h0000_0000);
      summarize();
    end
    rv = prdata;
    ev = pslverr;
    @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
    xfer(1'b0, a, DATA_ZERO);
    chk(nm, e, rv);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic pulse(input int b);
    @(posedge clk);
    ext_lvl[b] <= 1'b1;
    repeat (4) @(posedge clk);
    ext_lvl[b] <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  initial begin
    rstn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = DATA_ZERO;
    ext_lvl = 4'h0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    rd(OFF_DIR, 32'h0000_0000, "dir reset");
    rd(OFF_PCOUNT, 32'h0000_0000, "pcount reset");
    xfer(1'b0, 12'h040, DATA_ZERO);
    chk("unmapped err", 32'h0000_0001, {31'h0000_0000, ev});
    repeat (3) pulse(3);
    rd(OFF_PCOUNT, 32'h0000_0003, "pcount edges");
    wr(OFF_PCOUNT, 32'h0000_1234);
    rd(OFF_PCOUNT, 32'h0000_1234, "pcount write");
    wr(OFF_PORT, 32'h0000_000A);
    wr(OFF_DIR, 32'h0000_000F);
    rd(OFF_PORT, 32'h0000_000A, "port latch");
    chk("pins gp out", 32'h0000_00FA, {24'h00_0000, pin_oe, pin_out});
    wr(OFF_DIR, 32'h0000_0000);
    ext_lvl <= 4'h5;
    repeat (4) @(posedge clk);
    rd(OFF_PORT, 32'h0000_0005, "port pins");
    ext_lvl <= 4'h0;
    wr(OFF_CTRL, 32'h0000_0007);
    wr(OFF_EDGE, 32'h0000_0001);
    wr(OFF_IRQEN, 32'h0000_0001);
    wr(OFF_COUNT, 32'h0000_0100);
    pulse(0);
    xfer(1'b0, OFF_VALUE0, DATA_ZERO);
    chk("capture value", 32'h0000_0100, rv & 32'hFFFF_FFFE);
    rd(OFF_FLAGS, 32'h0000_0001, "capture flag");
    chk("capture irq", 32'h0000_0001, {28'h000_0000, irq});
    wr(OFF_FLAGS, 32'h0000_000F);
    wr(OFF_CTRL, 32'h0000_0000);
    wr(OFF_IOSEL, 32'h0000_0002);
    wr(OFF_OUTACT, 32'h0000_0022);
    wr(OFF_IRQEN, 32'h0000_0002);
    wr(OFF_VALUE1, 32'h0000_0080);
    wr(OFF_COUNT, 32'h0000_0000);
    repeat (160) @(posedge clk);
    chk("compare pin", 32'h0000_0003, {30'h0000_0000, pin_oe[1], pin_out[1]});
    rd(OFF_DIR, 32'h0000_0000, "dir kept");
    rd(OFF_FLAGS, 32'h0000_0002, "compare flag");
    chk("compare irq", 32'h0000_0002, {28'h000_0000, irq});
    wr(OFF_FLAGS, 32'h0000_000F);
    wr(OFF_OUTACT, 32'h0000_0020);
    wr(OFF_FORCE, 32'h0000_0002);
    rd(OFF_FLAGS, 32'h0000_0000, "force no flag");
    chk("force pin", 32'h0000_0002, {30'h0000_0000, pin_oe[1], pin_out[1]});
    wr(OFF_OUTACT, 32'h0000_0000);
    repeat (3) @(posedge clk);
    chk("disconnect", 32'h0000_0000, {31'h0000_0000, pin_oe[1]});
    wr(OFF_CTRL, 32'h0000_0008);
    wr(OFF_IOSEL, 32'h0000_0008);
    wr(OFF_CH3, 32'h0000_0101);
    wr(OFF_PORT, 32'h0000_0000);
    wr(OFF_DIR, 32'h0000_0001);
    wr(OFF_VALUE3, 32'h0000_0040);
    wr(OFF_COUNT, 32'h0000_0000);
    repeat (100) @(posedge clk);
    rd(OFF_PORT, 32'h0000_0001, "ch3 to port");
    chk("ch3 gp pin", 32'h0000_0003, {30'h0000_0000, pin_oe[0], pin_out[0]});
    xfer(1'b0, OFF_COUNT, DATA_ZERO);
    chk("count reset", 32'h0000_0001, {31'h0000_0000, rv < 32'h0000_0041});
    ce <= 1'b0;
    pulse(3);
    ce <= 1'b1;
    rd(OFF_PCOUNT, 32'h0000_1235, "pcount frozen");
    summarize();
  end
endmodule
`default_nettype wire
